// ==== rtl/lcd_pkg.sv ====
package lcd_pkg;

	// Clock and busy timing.
	localparam int CLK_PERIOD_NS    = 40;
	localparam int INSTR_TIME_NS    = 72000;
	localparam int INSTR_CYCLES     = (INSTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLEAR_TIME_NS    = 1600000;
	localparam int CLEAR_CYCLES_DEF = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W            = 16;

	// Widths and depths.
	localparam int BYTE_W     = 8;
	localparam int NIB_W      = 4;
	localparam int AC_W       = 7;
	localparam int GY_W       = 6;
	localparam int WORD_W     = 6;
	localparam int CODE_W     = 16;
	localparam int MEM_AW     = 12;
	localparam int MEM_DEPTH  = 2336;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_W     = MEM_AW + BYTE_W;

	// Byte address windows of the display memories.
	localparam logic [MEM_AW-1:0] BMP_BASE  = 12'h000;
	localparam logic [MEM_AW-1:0] CHR_BASE  = 12'h800;
	localparam logic [MEM_AW-1:0] FNT_BASE  = 12'h880;
	localparam logic [MEM_AW-1:0] ICN_BASE  = 12'h900;
	localparam logic [MEM_AW-1:0] MEM_LIMIT = MEM_AW'(MEM_DEPTH);
	localparam logic [AC_W-1:0]   ICON_WORDS = 7'h0F;

	// Font sets and code ranges.
	localparam int FULL_GLYPHS = 8192;
	localparam int HALF_GLYPHS = 126;
	localparam int USER_GLYPHS = 4;
	localparam logic [CODE_W-1:0] BIG5_LO = 16'hA140;
	localparam logic [CODE_W-1:0] BIG5_HI = 16'hD75F;
	localparam logic [CODE_W-1:0] GB_LO   = 16'hA1A0;
	localparam logic [CODE_W-1:0] GB_HI   = 16'hF7FF;
	localparam logic [11:0]       USER_UPPER_ZERO = 12'h000;
	localparam logic [BYTE_W-1:0] HALF_LO = 8'h02;
	localparam logic [BYTE_W-1:0] HALF_HI = 8'h7F;
	localparam logic [1:0]        VISIBLE_LINES = 2'h2;

	// Instruction fields.
	localparam logic [BYTE_W-1:0] CMD_CLEAR    = 8'h01;
	localparam int                FS_WIDTH_BIT = 4;
	localparam int                FS_EXT_BIT   = 2;
	localparam int                EM_INC_BIT   = 1;

	// Reset values.
	localparam logic RESET_WIDTH8 = 1'b1;
	localparam logic RESET_INCR   = 1'b1;

	typedef enum logic [3:0] {
		TGT_CHR = 4'h1,
		TGT_FNT = 4'h2,
		TGT_ICN = 4'h4,
		TGT_BMP = 4'h8
	} target_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_EXEC = 2'h2
	} ctl_state_t;

	typedef enum logic [4:0] {
		GL_NONE = 5'h01,
		GL_USER = 5'h02,
		GL_HALF = 5'h04,
		GL_BIG5 = 5'h08,
		GL_GB   = 5'h10
	} glyph_t;

endpackage : lcd_pkg

// ==== rtl/stream_if.sv ====
`timescale 1ns/100ps
interface stream_if #(
	parameter int W = 8
) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : stream_if

// ==== rtl/byte_fifo.sv ====
`timescale 1ns/100ps
module byte_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic ref_clk_i,
	input  wire logic rstn_i,
	input  wire logic clk_en_i,
	stream_if.snk     in_s,
	stream_if.src     out_s
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wp;
		logic [PW-1:0]           rp;
		logic [PW:0]             cnt;
	} fifo_t;

	fifo_t s_reg;
	fifo_t s_next;
	logic  push;
	logic  pop;

	assign in_s.ready  = (s_reg.cnt != (PW+1)'(DEPTH));
	assign out_s.valid = (s_reg.cnt != '0);
	assign out_s.data  = s_reg.mem[s_reg.rp];
	assign push        = in_s.valid && in_s.ready;
	assign pop         = out_s.valid && out_s.ready;

	always_comb begin
		s_next = s_reg;
		if (push) begin
			s_next.mem[s_reg.wp] = in_s.data;
			s_next.wp            = PW'((s_reg.wp + 1) % DEPTH);
		end
		if (pop) begin
			s_next.rp = PW'((s_reg.rp + 1) % DEPTH);
		end
		case ({push, pop})
			2'h2:    s_next.cnt = s_reg.cnt + (PW+1)'(1);
			2'h1:    s_next.cnt = s_reg.cnt - (PW+1)'(1);
			default: s_next.cnt = s_reg.cnt;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_reg <= '0;
		end else if (clk_en_i) begin
			s_reg <= s_next;
		end
	end
endmodule : byte_fifo

// ==== rtl/display_mem.sv ====
`timescale 1ns/100ps
module display_mem (
	input  wire logic                       ref_clk_i,
	input  wire logic                       rstn_i,
	input  wire logic                       clk_en_i,
	stream_if.snk                           wr_s,
	input  wire logic                       rd_hold_i,
	input  wire logic [lcd_pkg::MEM_AW-1:0] rd_addr_i,
	output logic      [lcd_pkg::BYTE_W-1:0] rd_data_o
);
	import lcd_pkg::*;

	typedef struct packed {
		logic [MEM_DEPTH-1:0][BYTE_W-1:0] mem;
		logic [BYTE_W-1:0]                rdata;
	} mem_t;

	mem_t                s_reg;
	mem_t                s_next;
	logic [MEM_AW-1:0]   wr_addr;
	logic [BYTE_W-1:0]   wr_data;

	// Writes wait while the host is reading so the read byte stays steady on the pins.
	assign wr_s.ready = !rd_hold_i;
	assign wr_addr    = wr_s.data[FIFO_W-1:BYTE_W];
	assign wr_data    = wr_s.data[BYTE_W-1:0];
	assign rd_data_o  = s_reg.rdata;

	always_comb begin
		s_next = s_reg;
		if (wr_s.valid && wr_s.ready && (wr_addr < MEM_LIMIT)) begin
			s_next.mem[wr_addr] = wr_data;
		end
		s_next.rdata = (rd_addr_i < MEM_LIMIT) ? s_reg.mem[rd_addr_i] : '0;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_reg <= '0;
		end else if (clk_en_i) begin
			s_reg <= s_next;
		end
	end
endmodule : display_mem

// ==== rtl/char_lcd_host_port.sv ====
`timescale 1ns/100ps
module char_lcd_host_port #(
	parameter int CLEAR_CYCLES = lcd_pkg::CLEAR_CYCLES_DEF
) (
	input  wire logic                       ref_clk_i,
	input  wire logic                       rstn_i,
	input  wire logic                       clk_en_i,
	input  wire logic                       interface_select_pin_i,
	input  wire logic                       register_select_i,
	input  wire logic                       read_not_write_i,
	input  wire logic                       bus_strobe_i,
	input  wire logic [lcd_pkg::BYTE_W-1:0] data_bus_lines_i,
	output logic      [lcd_pkg::BYTE_W-1:0] data_bus_lines_o,
	output logic                            data_bus_lines_oe_o,
	output logic                            busy_indicator_o,
	output logic                            glyph_valid_o,
	output lcd_pkg::glyph_t                 glyph_kind_o,
	output logic      [lcd_pkg::CODE_W-1:0] glyph_code_o,
	output logic      [lcd_pkg::WORD_W-1:0] glyph_word_o,
	output logic      [1:0]                 glyph_half_o,
	output logic                            glyph_visible_o
);
	import lcd_pkg::*;

	typedef struct packed {
		logic [1:0]             psb_s;
		logic [1:0]             rs_s;
		logic [1:0]             rw_s;
		logic [2:0]             e_s;
		logic [1:0][BYTE_W-1:0] db_s;
		ctl_state_t             st;
		logic [CNT_W-1:0]       cnt;
		logic                   width8;
		logic                   ext;
		logic                   incr;
		logic                   nib_ph;
		logic                   byte_ph;
		logic                   gd_second;
		target_t                tgt;
		logic [AC_W-1:0]        ac;
		logic [GY_W-1:0]        gy;
		logic [NIB_W-1:0]       nib_hi;
		logic [BYTE_W-1:0]      command_holding_register;
		logic [BYTE_W-1:0]      data_holding_register;
		logic [BYTE_W-1:0]      hi_byte;
		logic [BYTE_W-1:0]      dout;
		logic                   oe;
		logic                   gvalid;
		glyph_t                 gkind;
		logic [CODE_W-1:0]      gcode;
		logic [WORD_W-1:0]      gword;
		logic [1:0]             ghalf;
		logic                   gvis;
	} core_t;

	core_t               s_reg;
	core_t               s_next;
	logic                parallel;
	logic                rs;
	logic                rw;
	logic [BYTE_W-1:0]   db;
	logic                strobe_fall;
	logic                host_read;
	logic                busy;
	logic [MEM_AW-1:0]   cur_addr;
	logic [BYTE_W-1:0]   mem_rdata;
	logic                push_valid;
	logic [FIFO_W-1:0]   push_data;

	stream_if #(.W(FIFO_W)) push_s ();
	stream_if #(.W(FIFO_W)) drain_s ();

	function automatic logic [MEM_AW-1:0] mem_addr(input target_t t, input logic [AC_W-1:0] ac,
			input logic [GY_W-1:0] gy, input logic ph);
		case (t)
			TGT_BMP: mem_addr = BMP_BASE | {1'b0, gy, ac[3:0], ph};
			TGT_FNT: mem_addr = FNT_BASE | {5'h00, ac[5:0], ph};
			TGT_ICN: mem_addr = ICN_BASE | {7'h00, ac[3:0], ph};
			default: mem_addr = CHR_BASE | {5'h00, ac[5:0], ph};
		endcase
	endfunction : mem_addr

	function automatic logic is_half(input logic [BYTE_W-1:0] b);
		is_half = (b >= HALF_LO) && (b <= HALF_HI);
	endfunction : is_half

	// Where the two wide sets overlap the first one wins; the display side has no way to tell them apart.
	function automatic glyph_t classify(input logic [CODE_W-1:0] c);
		if (c[CODE_W-1:4] == USER_UPPER_ZERO) begin
			classify = GL_USER;
		end else if ((c >= BIG5_LO) && (c <= BIG5_HI)) begin
			classify = GL_BIG5;
		end else if ((c >= GB_LO) && (c <= GB_HI)) begin
			classify = GL_GB;
		end else if (is_half(c[15:8]) || is_half(c[7:0])) begin
			classify = GL_HALF;
		end else begin
			classify = GL_NONE;
		end
	endfunction : classify

	assign parallel    = s_reg.psb_s[1];
	assign rs          = s_reg.rs_s[1];
	assign rw          = s_reg.rw_s[1];
	assign db          = s_reg.db_s[1];
	assign strobe_fall = parallel && s_reg.e_s[2] && !s_reg.e_s[1];
	assign host_read   = parallel && s_reg.e_s[1] && rw;
	assign busy        = (s_reg.st == ST_EXEC) || !push_s.ready;
	assign cur_addr    = mem_addr(s_reg.tgt, s_reg.ac, s_reg.gy, s_reg.byte_ph);

	assign push_s.valid = push_valid;
	assign push_s.data  = push_data;

	byte_fifo #(
		.W     (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.clk_en_i  (clk_en_i),
		.in_s      (push_s),
		.out_s     (drain_s)
	);

	display_mem u_mem (
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.clk_en_i  (clk_en_i),
		.wr_s      (drain_s),
		.rd_hold_i (host_read),
		.rd_addr_i (cur_addr),
		.rd_data_o (mem_rdata)
	);

	always_comb begin
		logic [BYTE_W-1:0] rx;
		logic [BYTE_W-1:0] rb;
		logic              done;
		rx         = '0;
		rb         = '0;
		done       = 1'b0;
		push_valid = 1'b0;
		push_data  = '0;
		s_next     = s_reg;

		s_next.psb_s  = {s_reg.psb_s[0], interface_select_pin_i};
		s_next.rs_s   = {s_reg.rs_s[0], register_select_i};
		s_next.rw_s   = {s_reg.rw_s[0], read_not_write_i};
		s_next.e_s    = {s_reg.e_s[1:0], bus_strobe_i};
		s_next.db_s   = {s_reg.db_s[0], data_bus_lines_i};
		s_next.gvalid = 1'b0;

		case (s_reg.st)
			ST_IDLE: begin
				s_next.st = ST_IDLE;
			end
			ST_EXEC: begin
				if (s_reg.cnt == '0) begin
					s_next.st = ST_IDLE;
				end else begin
					s_next.cnt = s_reg.cnt - 16'h0001;
				end
			end
			default: begin
				s_next.st = ST_IDLE;
			end
		endcase

		// The data register follows the memory at the pointer so a read finds its byte already waiting.
		s_next.data_holding_register = mem_rdata;

		if (strobe_fall) begin
			if (s_reg.width8) begin
				rx   = db;
				done = 1'b1;
			end else if (!s_reg.nib_ph) begin
				s_next.nib_hi = db[7:4];
				s_next.nib_ph = 1'b1;
			end else begin
				rx            = {s_reg.nib_hi, db[7:4]};
				done          = 1'b1;
				s_next.nib_ph = 1'b0;
			end
		end

		if (done) begin
			case ({rs, rw})
				2'h0: begin
					if (!busy) begin
						s_next.command_holding_register = rx;
						s_next.st        = ST_EXEC;
						s_next.cnt       = CNT_W'(INSTR_CYCLES - 1);
						s_next.gd_second = 1'b0;
						casez (rx)
							8'b1???????: begin
								s_next.byte_ph = 1'b0;
								if (!s_reg.ext) begin
									s_next.tgt = TGT_CHR;
									s_next.ac  = rx[6:0];
								end else if (!s_reg.gd_second) begin
									s_next.gy        = rx[5:0];
									s_next.gd_second = 1'b1;
								end else begin
									s_next.ac  = {3'h0, rx[3:0]};
									s_next.tgt = TGT_BMP;
								end
							end
							8'b01??????: begin
								s_next.tgt     = s_reg.ext ? TGT_ICN : TGT_FNT;
								s_next.ac      = {1'b0, rx[5:0]};
								s_next.byte_ph = 1'b0;
							end
							8'b001?????: begin
								s_next.width8 = rx[FS_WIDTH_BIT];
								s_next.ext    = rx[FS_EXT_BIT];
								s_next.nib_ph = 1'b0;
							end
							8'b000001??: begin
								if (!s_reg.ext) begin
									s_next.incr = rx[EM_INC_BIT];
								end
							end
							8'b0000001?, 8'b00000001: begin
								if (!s_reg.ext) begin
									s_next.ac      = '0;
									s_next.tgt     = TGT_CHR;
									s_next.byte_ph = 1'b0;
									if (rx == CMD_CLEAR) begin
										s_next.incr = RESET_INCR;
										s_next.cnt  = CNT_W'(CLEAR_CYCLES - 1);
									end
								end
							end
							default: begin
								s_next.st = ST_EXEC;
							end
						endcase
					end
				end
				2'h2: begin
					// A full queue shows as busy; a write sent anyway is dropped and the pointer holds.
					if (push_s.ready && !((s_reg.tgt == TGT_ICN) && (s_reg.ac >= ICON_WORDS))) begin
						push_valid = 1'b1;
						push_data  = {cur_addr, rx};
						if (!s_reg.byte_ph) begin
							s_next.hi_byte = rx;
							s_next.byte_ph = 1'b1;
						end else begin
							s_next.byte_ph = 1'b0;
							s_next.ac      = s_reg.incr ? s_reg.ac + 7'h01 : s_reg.ac - 7'h01;
							if (s_reg.tgt == TGT_CHR) begin
								// Only a completed, word-aligned pair is judged as a code.
								s_next.gvalid = 1'b1;
								s_next.gcode  = {s_reg.hi_byte, rx};
								s_next.gkind  = classify({s_reg.hi_byte, rx});
								s_next.gword  = s_reg.ac[5:0];
								s_next.ghalf  = {is_half(s_reg.hi_byte), is_half(rx)};
								s_next.gvis   = (s_reg.ac[5:4] < VISIBLE_LINES);
							end
						end
					end
				end
				2'h3: begin
					if (!s_reg.byte_ph) begin
						s_next.byte_ph = 1'b1;
					end else begin
						s_next.byte_ph = 1'b0;
						s_next.ac      = s_reg.incr ? s_reg.ac + 7'h01 : s_reg.ac - 7'h01;
					end
				end
				default: begin
					s_next.st = s_next.st;
				end
			endcase
		end

		rb        = rs ? s_reg.data_holding_register : {busy, s_reg.ac};
		s_next.oe = host_read;
		if (s_reg.width8) begin
			s_next.dout = rb;
		end else begin
			s_next.dout = s_reg.nib_ph ? {rb[3:0], 4'h0} : {rb[7:4], 4'h0};
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_reg        <= '0;
			s_reg.st     <= ST_IDLE;
			s_reg.width8 <= RESET_WIDTH8;
			s_reg.incr   <= RESET_INCR;
			s_reg.tgt    <= TGT_CHR;
			s_reg.gkind  <= GL_NONE;
		end else if (clk_en_i) begin
			s_reg <= s_next;
		end
	end

	assign data_bus_lines_o    = s_reg.dout;
	assign data_bus_lines_oe_o = s_reg.oe;
	assign busy_indicator_o    = busy;
	assign glyph_valid_o       = s_reg.gvalid;
	assign glyph_kind_o        = s_reg.gkind;
	assign glyph_code_o        = s_reg.gcode;
	assign glyph_word_o        = s_reg.gword;
	assign glyph_half_o        = s_reg.ghalf;
	assign glyph_visible_o     = s_reg.gvis;
endmodule : char_lcd_host_port

// ==== sim/lcd_host_model.sv ====
`timescale 1ns/100ps
module lcd_host_model (
	input  wire logic       ref_clk_i,
	input  wire logic [7:0] db_i,
	output logic            register_select_o,
	output logic            read_not_write_o,
	output logic            bus_strobe_o,
	output logic      [7:0] db_o
);
	logic nib_mode;

	initial begin
		register_select_o = 1'b0;
		read_not_write_o  = 1'b0;
		bus_strobe_o      = 1'b0;
		db_o              = 8'h00;
		nib_mode          = 1'b0;
	end

	// One strobe pulse; select, direction and data stay put from the rise until well after the fall.
	task automatic xfer(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
		@(posedge ref_clk_i);
		#1;
		register_select_o = rs;
		read_not_write_o = rw;
		db_o = rw ? ~db_o : d;
		bus_strobe_o = 1'b1;
		repeat (6) @(posedge ref_clk_i);
		q = db_i;
		#1 bus_strobe_o = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		// A released bus must not keep its last value, or a missed sample could pass.
		#1 db_o = ~db_o;
	endtask : xfer

	task automatic acc(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
		logic [7:0] a;
		logic [7:0] b;
		if (nib_mode) begin
			xfer(rs, rw, {d[7:4], 4'h5}, a);
			xfer(rs, rw, {d[3:0], 4'hA}, b);
			q = {a[7:4], b[7:4]};
		end else begin
			xfer(rs, rw, d, q);
		end
		if (!rs && !rw && d[7:5] == 3'h1) begin
			nib_mode = !d[4];
		end
	endtask : acc
endmodule : lcd_host_model

// ==== sim/char_lcd_host_port_sva.sv ====
`timescale 1ns/100ps
module lcd_port_chk #(
	parameter int CLEAR_CYCLES = 20
) (
	input wire logic                       ref_clk_i,
	input wire logic                       rstn_i,
	input wire logic                       interface_select_pin_i,
	input wire logic                       register_select_i,
	input wire logic                       read_not_write_i,
	input wire logic                       bus_strobe_i,
	input wire logic                       data_bus_lines_oe_o,
	input wire logic                       busy_indicator_o,
	input wire logic                       glyph_valid_o,
	input lcd_pkg::glyph_t                 glyph_kind_o,
	input wire logic [lcd_pkg::CODE_W-1:0] glyph_code_o,
	input wire logic [lcd_pkg::WORD_W-1:0] glyph_word_o,
	input wire logic [1:0]                 glyph_half_o,
	input wire logic                       glyph_visible_o
);
	import lcd_pkg::*;
	logic [CNT_W-1:0] run_len_reg;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			run_len_reg <= '0;
		end else begin
			run_len_reg <= busy_indicator_o ? run_len_reg + 1'b1 : '0;
		end
	end

	// Pins pass two synchroniser stages and one state stage, so causes lie three samples back.
	sequence wr_fall_s;
		$past(bus_strobe_i, 4) && !$past(bus_strobe_i, 3) && !$past(read_not_write_i, 3);
	endsequence
	sequence busy_run_s;
		busy_indicator_o [*8];
	endsequence

	oe_select_a: assert property (!$past(interface_select_pin_i, 3) && !$past(interface_select_pin_i, 4) |-> !data_bus_lines_oe_o)
		else $error("bus driven while port deselected");
	oe_read_a: assert property (data_bus_lines_oe_o |-> $past(bus_strobe_i, 3) && $past(read_not_write_i, 3))
		else $error("bus driven outside a read strobe");
	busy_cause_a: assert property ($rose(busy_indicator_o) |-> wr_fall_s)
		else $error("busy rose without a write");
	busy_hold_a: assert property ($rose(busy_indicator_o) && !$past(register_select_i, 3) |-> busy_run_s)
		else $error("instruction busy too short");
	busy_len_a: assert property ($fell(busy_indicator_o) |->
		run_len_reg == CNT_W'(INSTR_CYCLES) || run_len_reg == CNT_W'(CLEAR_CYCLES))
		else $error("busy length wrong");
	kind_onehot_a: assert property (glyph_valid_o |-> $onehot(glyph_kind_o))
		else $error("glyph kind not one-hot");
	glyph_pulse_a: assert property (glyph_valid_o |=> (!glyph_valid_o) [*8])
		else $error("glyph valid too long");
	half_flags_a: assert property (glyph_valid_o |-> glyph_half_o ==
		{glyph_code_o[15:8] >= HALF_LO && glyph_code_o[15:8] <= HALF_HI,
		glyph_code_o[7:0] >= HALF_LO && glyph_code_o[7:0] <= HALF_HI})
		else $error("half flags wrong");
	visible_line_a: assert property (glyph_valid_o |-> glyph_visible_o == (glyph_word_o[5:4] < VISIBLE_LINES))
		else $error("visibility wrong");
	user_code_a: assert property (glyph_valid_o && glyph_code_o[15:4] == USER_UPPER_ZERO |-> glyph_kind_o == GL_USER)
		else $error("user glyph not flagged");
	set_a_code_a: assert property (glyph_valid_o && glyph_code_o >= BIG5_LO && glyph_code_o <= BIG5_HI
		|-> glyph_kind_o == GL_BIG5)
		else $error("code set A not flagged");
endmodule : lcd_port_chk

bind char_lcd_host_port lcd_port_chk #(.CLEAR_CYCLES(CLEAR_CYCLES)) chk_u (
	.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .interface_select_pin_i(interface_select_pin_i),
	.register_select_i(register_select_i), .read_not_write_i(read_not_write_i), .bus_strobe_i(bus_strobe_i),
	.data_bus_lines_oe_o(data_bus_lines_oe_o), .busy_indicator_o(busy_indicator_o), .glyph_valid_o(glyph_valid_o),
	.glyph_kind_o(glyph_kind_o), .glyph_code_o(glyph_code_o), .glyph_word_o(glyph_word_o),
	.glyph_half_o(glyph_half_o), .glyph_visible_o(glyph_visible_o));

// ==== sim/test_char_lcd_host_port.sv ====
`timescale 1ns/100ps
module test_char_lcd_host_port;
	import lcd_pkg::*;
	localparam int CLR = 20;
	logic        ref_clk_i, rstn_i, sel, rs, rw, e, oe, busy, gv, gvis, g_vis;
	int          oe_cnt = 0;
	int          oe_mark;
	logic [7:0]  dout, dbus, hdb, q;
	logic [15:0] gc, g_code;
	logic [5:0]  gw, g_word;
	logic [1:0]  gh, g_half;
	glyph_t      gk, g_kind;
	int          num_errors, samples_checked;
	logic [15:0] codes [5] = '{16'hA140, 16'hF000, 16'h4142, 16'h0006, 16'hA1A0};
	glyph_t      kinds [5] = '{GL_BIG5, GL_GB, GL_HALF, GL_USER, GL_BIG5};

	assign dbus = (oe === 1'b1) ? dout : hdb;

	char_lcd_host_port #(.CLEAR_CYCLES(CLR)) DUT (
		.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(1'b1), .interface_select_pin_i(sel),
		.register_select_i(rs), .read_not_write_i(rw), .bus_strobe_i(e), .data_bus_lines_i(dbus),
		.data_bus_lines_o(dout), .data_bus_lines_oe_o(oe), .busy_indicator_o(busy), .glyph_valid_o(gv),
		.glyph_kind_o(gk), .glyph_code_o(gc), .glyph_word_o(gw), .glyph_half_o(gh), .glyph_visible_o(gvis));

	lcd_host_model h (.ref_clk_i(ref_clk_i), .db_i(dbus), .register_select_o(rs),
		.read_not_write_o(rw), .bus_strobe_o(e), .db_o(hdb));

	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	// The glyph strobe lasts one cycle, so its payload is caught here for later comparison.
	always @(posedge ref_clk_i) begin
		if (gv === 1'b1) begin
			g_code <= gc;
			g_kind <= gk;
			g_word <= gw;
			g_half <= gh;
			g_vis  <= gvis;
		end
		if (oe === 1'b1) oe_cnt <= oe_cnt + 1;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks=%0d errors=%0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim

	task automatic wait_idle();
		int n;
		n = 0;
		q = 8'h80;
		while (q[7] !== 1'b0 && n < 400) begin
			h.acc(1'b0, 1'b1, 8'h00, q);
			n++;
		end
		chk(16'(n < 400), 16'h1);
	endtask : wait_idle

	task automatic cmd(input logic [7:0] d);
		h.acc(1'b0, 1'b0, d, q);
		wait_idle();
	endtask : cmd

	task automatic st(input logic [7:0] exp);
		h.acc(1'b0, 1'b1, 8'h00, q);
		chk(q, exp);
	endtask : st

	task automatic wr2(input logic [15:0] v);
		h.acc(1'b1, 1'b0, v[15:8], q);
		h.acc(1'b1, 1'b0, v[7:0], q);
		repeat (3) @(posedge ref_clk_i);
		#1;
	endtask : wr2

	task automatic rd2(input logic [15:0] exp);
		logic [7:0] a;
		h.acc(1'b1, 1'b1, 8'h00, a);
		h.acc(1'b1, 1'b1, 8'h00, q);
		chk({a, q}, exp);
	endtask : rd2

	initial begin
		repeat (100000) @(posedge ref_clk_i);
		num_errors++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end_sim();
	end

	initial begin
		sel = 1'b1;
		rstn_i = 1'b0;
		oe_mark = 0;
		num_errors = 0;
		samples_checked = 0;
		repeat (5) @(posedge ref_clk_i);
		#1 rstn_i = 1'b1;
		repeat (3) @(posedge ref_clk_i);
		chk(oe, 1'b0);
		chk(busy, 1'b0);
		st(8'h00);
		h.acc(1'b0, 1'b0, 8'h83, q);
		chk(busy, 1'b1);
		h.acc(1'b0, 1'b0, 8'h85, q);
		wait_idle();
		st(8'h03);
		for (int i = 0; i < 5; i++) begin
			wr2(codes[i]);
			chk(g_code, codes[i]);
			chk(g_kind, kinds[i]);
			chk(g_word, 16'(3 + i));
		end
		st(8'h08);
		cmd(8'h83);
		rd2(16'hA140);
		st(8'h04);
		cmd(8'hA0);
		wr2(16'h4142);
		chk(g_vis, 1'b0);
		chk(g_half, 2'h3);
		cmd(8'h04);
		cmd(8'h85);
		wr2(16'h2020);
		st(8'h04);
		cmd(8'h01);
		st(8'h00);
		cmd(8'h34);
		cmd(8'h4E);
		wr2(16'h1234);
		st(8'h0F);
		wr2(16'h5678);
		st(8'h0F);
		cmd(8'h4E);
		rd2(16'h1234);
		cmd(8'h85);
		cmd(8'h82);
		wr2(16'hABCD);
		wr2(16'hEF01);
		cmd(8'h85);
		cmd(8'h83);
		rd2(16'hEF01);
		cmd(8'h85);
		cmd(8'h82);
		rd2(16'hABCD);
		cmd(8'h30);
		cmd(8'h20);
		cmd(8'h81);
		wr2(16'h5AA5);
		cmd(8'h81);
		rd2(16'h5AA5);
		st(8'h02);
		cmd(8'h30);
		@(posedge ref_clk_i);
		#1 sel = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		#1 oe_mark = oe_cnt;
		h.acc(1'b1, 1'b0, 8'h77, q);
		h.acc(1'b0, 1'b1, 8'h00, q);
		chk(16'(oe_cnt - oe_mark), 16'h0);
		@(posedge ref_clk_i);
		#1 sel = 1'b1;
		repeat (4) @(posedge ref_clk_i);
		st(8'h02);
		cmd(8'h41);
		wr2(16'hC3C3);
		cmd(8'h41);
		rd2(16'hC3C3);
		cmd(8'h02);
		st(8'h00);
		end_sim();
	end
endmodule : test_char_lcd_host_port
